//--- ssd_consts.vh
// constants for the serial-in latched sink driver block
// What this block does
// [RULE_01] each serial clock rising edge loads the data input into stage zero
// [RULE_02] later serial clock edges move every stage one place toward the cascade output
// [RULE_03] a latch pulse rising edge copies all stages into the output latches together
// [RULE_04] output gate high turns every sink line off regardless of latches
// [RULE_05] output gate never alters the stored latch contents
// [RULE_06] output gate low lets each sink line follow its own latch
// [RULE_07] stage clear low forces all shift stages to zero
// [RULE_08] cascade output is driven from the final shift stage
// [RULE_09] eight shift stages, eight latches and eight sink lines, one latch each
// [RULE_10] stage clear acts at once on stages only, latches untouched; here it waits two sync flops and also flushes the fifo
// [RULE_11] host shifts eight bits per device then gives one latch pulse
`ifndef SSD_CONSTS_VH
`define SSD_CONSTS_VH
`define SSD_WIDTH 8
`define SSD_STAGE_RESET 8'h00
`define SSD_LATCH_RESET 8'h00
`define SSD_FIFO_DEPTH 8
`define SSD_SYNC_STAGES 2
`endif

//--- ssd_sync.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module ssd_sync (
    sys_clk,   // block clock
    reset_n,   // async reset, active low
    pin_in,    // asynchronous pin level
    sync_out   // level in sys_clk domain
);
    parameter RESET_VAL = 1'b0;
    input wire sys_clk;
    input wire reset_n;
    input wire pin_in;
    output reg sync_out;
    reg meta_r;

    // first flop feeds only the second
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_r <= pin_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- ssd_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module ssd_fifo (
    sys_clk,   // block clock
    reset_n,   // async reset, active low
    flush,     // drop all contents
    in_data,   // write data
    in_valid,  // write request
    in_ready,  // room available
    out_data,  // head word
    out_valid, // head word present
    out_ready  // reader takes head
);
    parameter WIDTH = 8;
    parameter DEPTH = 8;
    parameter AW = 3;
    input wire sys_clk;
    input wire reset_n;
    input wire flush;
    input wire [WIDTH-1:0] in_data;
    input wire in_valid;
    output wire in_ready;
    output wire [WIDTH-1:0] out_data;
    output wire out_valid;
    input wire out_ready;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire do_wr;
    wire do_rd;

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr_r];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // storage array, no reset needed
    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill count; depth assumed a power of two
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else if (flush) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

//--- ssd_driver.v
// serial-in latched sink driver: shift stages, latches, gating, cascade
`timescale 1ns/100ps
`include "ssd_consts.vh"
module ssd_driver (
    sys_clk,          // 200 MHz block clock
    reset_n,          // async reset, active low
    ser_clk,          // serial clock pin
    ser_data,         // serial data pin
    latch_pulse,      // latch pulse pin, rising edge acts
    out_gate_n,       // output gate pin, active low
    stage_clr_n,      // stage clear pin, active low
    sink_lines,       // sink drive, 1 = sink on
    cascade_out,      // serial output to next device
    bits_ready,       // fifo holds a bit not yet shifted
    bit_overflow      // a sampled bit found the fifo full
);
    parameter WIDTH = `SSD_WIDTH;
    parameter DEPTH = `SSD_FIFO_DEPTH;
    input wire sys_clk;
    input wire reset_n;
    input wire ser_clk;
    input wire ser_data;
    input wire latch_pulse;
    input wire out_gate_n;
    input wire stage_clr_n;
    output reg [WIDTH-1:0] sink_lines;
    output reg cascade_out;
    output reg bits_ready;
    output reg bit_overflow;

    wire clk_s;
    wire data_s;
    wire latch_s;
    wire gate_n_s;
    wire clr_n_s;
    reg clk_d_r;
    reg latch_d_r;
    reg [WIDTH-1:0] stage_r;
    reg [WIDTH-1:0] latch_r;
    wire clk_rise;
    wire latch_rise;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_bit;
    wire stage_take;

    // pin conditioning; serial clock and data pass through equal delay
    ssd_sync #(.RESET_VAL(1'b0)) u_sync_clk (
        .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(ser_clk), .sync_out(clk_s));
    ssd_sync #(.RESET_VAL(1'b0)) u_sync_data (
        .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(ser_data), .sync_out(data_s));
    ssd_sync #(.RESET_VAL(1'b0)) u_sync_latch (
        .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(latch_pulse), .sync_out(latch_s));
    ssd_sync #(.RESET_VAL(1'b1)) u_sync_gate (
        .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(out_gate_n), .sync_out(gate_n_s));
    ssd_sync #(.RESET_VAL(1'b1)) u_sync_clr (
        .sys_clk(sys_clk), .reset_n(reset_n), .pin_in(stage_clr_n), .sync_out(clr_n_s));

    // edge memory on synchronised levels only
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_d_r <= 1'b0;
            latch_d_r <= 1'b0;
        end else begin
            clk_d_r <= clk_s;
            latch_d_r <= latch_s;
        end
    end

    assign clk_rise = clk_s && !clk_d_r;
    assign latch_rise = latch_s && !latch_d_r;

    // sampled bits queue here; a clear drops queued bits too
    ssd_fifo #(.WIDTH(1), .DEPTH(DEPTH), .AW(3)) u_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .flush(!clr_n_s),
        .in_data(data_s),
        .in_valid(clk_rise),
        .in_ready(fifo_in_ready),
        .out_data(fifo_bit),
        .out_valid(fifo_out_valid),
        .out_ready(stage_take)
    );

    // stages take one bit per cycle; stall while a latch copy is due so it sees the host's order
    assign stage_take = fifo_out_valid && clr_n_s && !latch_rise;

    // shift chain toward the cascade end
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_r <= `SSD_STAGE_RESET;
        end else if (!clr_n_s) begin
            stage_r <= `SSD_STAGE_RESET; // [RULE_07] [RULE_10]
        end else if (stage_take) begin
            stage_r <= {stage_r[WIDTH-2:0], fifo_bit}; // [RULE_01] [RULE_02] [RULE_09]
        end
    end

    // latches load only on the latch edge; gate and clear never touch them
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            latch_r <= `SSD_LATCH_RESET;
        end else if (latch_rise) begin
            latch_r <= stage_r; // [RULE_03] [RULE_05] [RULE_10]
        end
    end

    // registered outputs
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sink_lines <= {WIDTH{1'b0}};
            cascade_out <= 1'b0;
            bits_ready <= 1'b0;
            bit_overflow <= 1'b0;
        end else begin
            sink_lines <= gate_n_s ? {WIDTH{1'b0}} : latch_r; // [RULE_04] [RULE_06]
            cascade_out <= stage_r[WIDTH-1]; // [RULE_08]
            bits_ready <= fifo_out_valid;
            bit_overflow <= clk_rise && !fifo_in_ready;
        end
    end
endmodule

//--- ssd_monitor.sv
// port checker for the sink driver
`timescale 1ns/100ps
module ssd_monitor #(parameter WIDTH = 8) (
    input wire sys_clk, // clock
    input wire reset_n, // reset
    input wire ser_clk, // link clock
    input wire latch_pulse, // latch pin
    input wire out_gate_n, // gate pin
    input wire stage_clr_n, // clear pin
    input wire [WIDTH-1:0] sink_lines, // sinks
    input wire cascade_out, // cascade
    input wire bits_ready, // fifo status
    input wire bit_overflow // lost bit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // gate pin effects reach sink_lines three edges later, two of them in the synchronisers
    chk_gate_blank: assert property (out_gate_n [*4] |-> sink_lines == 0) else $error("sink on blanked");
    chk_gate_open: assert property (sink_lines != 0 |-> !$past(out_gate_n, 3)) else $error("sink ungated");
    chk_sink_hold: assert property ((!latch_pulse && !out_gate_n) [*6] |=> $stable(sink_lines))
        else $error("sink moved");
    chk_clr_stage: assert property (!stage_clr_n [*5] |-> !cascade_out && !bits_ready)
        else $error("stages kept");
    chk_casc_still: assert property ((!ser_clk && stage_clr_n) [*8] |=> $stable(cascade_out))
        else $error("cascade moved");
    chk_casc_shift: assert property ($rose(cascade_out) |-> $past(ser_clk, 4) || $past(ser_clk, 5))
        else $error("cascade no shift");
    chk_ready_idle: assert property (!ser_clk [*8] |-> !bits_ready) else $error("bit stuck");
    chk_no_loss: assert property (!bit_overflow) else $error("bit lost");
endmodule
bind ssd_driver ssd_monitor #(.WIDTH(WIDTH)) i_ssd_monitor (.sys_clk(sys_clk), .reset_n(reset_n),
    .ser_clk(ser_clk), .latch_pulse(latch_pulse), .out_gate_n(out_gate_n), .stage_clr_n(stage_clr_n),
    .sink_lines(sink_lines), .cascade_out(cascade_out), .bits_ready(bits_ready), .bit_overflow(bit_overflow));

//--- ssd_host.sv
// host model: shifts bytes msb first, pulses the latch
`timescale 1ns/100ps
module ssd_host (
    output logic ser_clk, // link clock
    output logic ser_data, // link data
    output logic latch_pulse // latch pin
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_pulse = 1'b0;
    end
    // clock stands low between frames; data inverts once hold ends
    task send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ser_data = b[i];
            #12 ser_clk = 1'b1;
            #12 ser_data = ~b[i];
            #12 ser_clk = 1'b0;
            #12;
        end
    endtask
    // one latch edge after eight bits
    task strobe;
        #30 latch_pulse = 1'b1;
        #30 latch_pulse = 1'b0;
    endtask
endmodule

//--- ssd_driver_tb.sv
// self-checking bench for the sink driver
`timescale 1ns/100ps
module ssd_driver_tb;
    logic sys_clk, reset_n, out_gate_n, stage_clr_n;
    wire ser_clk, ser_data, latch_pulse, cascade_out, bits_ready, bit_overflow;
    wire [7:0] sink_lines;
    logic [7:0] b, prev;
    logic [31:0] rng = 32'h0000eaf6;
    int miscompares = 0, n_compared = 0;
    ssd_driver i_ssd_driver (.sys_clk(sys_clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .latch_pulse(latch_pulse), .out_gate_n(out_gate_n), .stage_clr_n(stage_clr_n), .sink_lines(sink_lines),
        .cascade_out(cascade_out), .bits_ready(bits_ready), .bit_overflow(bit_overflow));
    ssd_host i_ssd_host (.ser_clk(ser_clk), .ser_data(ser_data), .latch_pulse(latch_pulse));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // blanking wins over the latch
    function automatic logic [7:0] exp_sink(input logic [7:0] v, input logic g);
        return g ? 8'h00 : v;
    endfunction
    task chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task settle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // run needs about 7 us; stop hangs well beyond
    initial begin
        #200000;
        miscompares++;
        complete_run;
    end
    initial begin
        reset_n = 1'b0;
        out_gate_n = 1'b1;
        stage_clr_n = 1'b1;
        prev = 8'h00;
        settle(20);
        reset_n = 1'b1;
        settle(5);
        out_gate_n = 1'b0;
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            b = i == 0 ? 8'hff : i == 1 ? 8'h00 : i == 2 ? 8'h80 : i == 3 ? 8'h01 : rng[7:0];
            i_ssd_host.send(b);
            settle(6);
            chk("sink pre latch", exp_sink(prev, 1'b0), sink_lines);
            chk("cascade", {7'h00, b[7]}, {7'h00, cascade_out});
            chk("fifo drained", 8'h00, {6'h00, bits_ready, bit_overflow});
            i_ssd_host.strobe();
            settle(6);
            chk("sink latched", exp_sink(b, 1'b0), sink_lines);
            out_gate_n = 1'b1;
            settle(6);
            chk("sink blanked", exp_sink(b, 1'b1), sink_lines);
            out_gate_n = 1'b0;
            stage_clr_n = 1'b0;
            settle(8);
            chk("sink unblanked", exp_sink(b, 1'b0), sink_lines);
            chk("cascade cleared", 8'h00, {7'h00, cascade_out});
            stage_clr_n = 1'b1;
            settle(4);
            prev = b;
            $display("test %0d done", i);
        end
        complete_run;
    end
endmodule
